// file: design/mtc_pkg.sv
package mtc_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses, one word per register)
  // ----------------------------------------------------------------
  localparam logic [7:0] MTC_OFS_CTRL = 8'h00;
  localparam logic [7:0] MTC_OFS_CNTH = 8'h04;
  localparam logic [7:0] MTC_OFS_CNTL = 8'h08;
  localparam logic [7:0] MTC_OFS_PERH = 8'h0C;
  localparam logic [7:0] MTC_OFS_PERL = 8'h10;
  localparam logic [7:0] MTC_OFS_CHFL = 8'h14;
  localparam logic [7:0] MTC_OFS_CHCF = 8'h18;

  // ----------------------------------------------------------------
  // Reset values and fixed codes
  // ----------------------------------------------------------------
  localparam logic [7:0]  MTC_CTRL_RST = 8'h20;
  localparam logic [7:0]  MTC_PER_RST  = 8'hFF;
  localparam logic [7:0]  MTC_BYTE_0   = 8'h00;
  localparam logic [15:0] MTC_CNT_ZERO = 16'h0000;
  localparam logic [15:0] MTC_CNT_ONE  = 16'h0001;
  localparam logic [23:0] MTC_PAD_0    = 24'h000000;
  localparam logic [31:0] MTC_WORD_0   = 32'h00000000;
  localparam logic [2:0]  MTC_DIV_EXT  = 3'h7;
  localparam logic [6:0]  MTC_DIV_ONES = 7'h7F;
  localparam logic [6:0]  MTC_DIV_ZERO = 7'h00;
  localparam logic [6:0]  MTC_DIV_STEP = 7'h01;
  localparam logic [1:0]  MTC_CH_NONE  = 2'h0;

  // ----------------------------------------------------------------
  // Register layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       ovf;
    logic       ovfIe;
    logic       halt;
    logic       clr;
    logic       rsv;
    logic [2:0] divSel;
  } mtc_ctrl_t;

  typedef struct packed {
    logic [1:0] rsvHi;
    logic [1:0] irqEn;
    logic [1:0] rsvLo;
    logic [1:0] flag;
  } mtc_chfl_t;

  typedef struct packed {
    logic [1:0] rsvHi;
    logic [1:0] toggle;
    logic       rsvLo;
    logic       buffered;
    logic [1:0] compare;
  } mtc_chcf_t;

  typedef enum logic {MTC_BUS_IDLE, MTC_BUS_DATA} mtc_bus_t;

endpackage : mtc_pkg

// file: design/mtc_prescaler.sv
`timescale 1ns/1ps
module mtc_prescaler
  import mtc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Control
  input  wire logic       clear,
  input  wire logic       run,
  input  wire logic [2:0] divSel,
  // External count clock pin
  input  wire logic       extClkPin,
  // Count enable
  output logic            tick
);

  logic [6:0] divCnt;
  logic       extSync1;
  logic       extSync2;
  logic       extPrev;

  // ----------------------------------------------------------------
  // Selection
  // ----------------------------------------------------------------
  wire logic       selExt  = (divSel == MTC_DIV_EXT);
  wire logic [6:0] divMask = ~(MTC_DIV_ONES << divSel);
  wire logic       divHit  = ((divCnt & divMask) == divMask);
  wire logic       extRise = extSync2 && !extPrev;
  // Code zero gives an empty mask, so every cycle ticks
  assign tick = run && (selExt ? extRise : divHit);

  // Free divider, zeroed by the clear bit, frozen while halted
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      divCnt <= MTC_DIV_ZERO;
    end else if (clear) begin
      divCnt <= MTC_DIV_ZERO;
    end else if (run) begin
      divCnt <= divCnt + MTC_DIV_STEP;
    end
  end

  // Pin passes two flops before the edge detector looks at it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      extSync1 <= 1'b0;
      extSync2 <= 1'b0;
      extPrev  <= 1'b0;
    end else begin
      extSync1 <= extClkPin;
      extSync2 <= extSync1;
      extPrev  <= extSync2;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_ext_single_tick: assert property (
    selExt && tick |=> !tick)
    else $error("external clock gave two ticks in a row");

endmodule : mtc_prescaler

// file: design/mtc_timer.sv
// Local design decisions: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
module mtc_timer
  import mtc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // System state
  input  wire logic        waitMode,
  input  wire logic        stopMode,
  input  wire logic        breakState,
  input  wire logic        breakClearEnable,
  // External count clock pin
  input  wire logic        extClkPin,
  // Channel logic
  input  wire logic [1:0]  chEvent,
  input  wire logic [1:0]  chCompare,
  input  wire logic [1:0]  chCompareLevel,
  output mtc_chcf_t        chConfig,
  output logic [1:0]       chPinOut,
  output logic [1:0]       chPinOe,
  // Requests
  output logic             irqOverflow,
  output logic [1:0]       irqChannel,
  output logic             wakeRequest
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  mtc_bus_t   phase;
  logic [7:0] reqAddr;
  logic       reqWrite;
  mtc_ctrl_t  ctrl;
  mtc_chfl_t  chFl;
  logic [15:0] count;
  logic [7:0] perHigh;
  logic [7:0] perLow;
  logic       perPending;
  logic       ovfArmed;
  logic [1:0] chArmed;
  logic       latched;
  logic [7:0] latchLow;
  logic       tick;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Only word transfers are expected, so hsize is not decoded
  wire logic busReq     = hsel && htrans[1] && hready;
  wire logic hostBlock  = waitMode || stopMode;
  wire logic access     = (phase == MTC_BUS_DATA) && !hostBlock;
  wire logic wr         = access && reqWrite;
  wire logic rd         = access && !reqWrite;
  wire logic selCtrl    = (reqAddr == MTC_OFS_CTRL);
  wire logic selCntH    = (reqAddr == MTC_OFS_CNTH);
  wire logic selCntL    = (reqAddr == MTC_OFS_CNTL);
  wire logic selPerH    = (reqAddr == MTC_OFS_PERH);
  wire logic selPerL    = (reqAddr == MTC_OFS_PERL);
  wire logic selChFl    = (reqAddr == MTC_OFS_CHFL);
  wire logic selChCf    = (reqAddr == MTC_OFS_CHCF);
  wire logic wrCtrl     = wr && selCtrl;
  wire logic wrPerH     = wr && selPerH;
  wire logic wrPerL     = wr && selPerL;
  wire logic wrChFl     = wr && selChFl;
  wire logic wrChCf     = wr && selChCf;
  wire logic rdCtrl     = rd && selCtrl;
  wire logic rdCntH     = rd && selCntH;
  wire logic rdCntL     = rd && selCntL;
  wire logic rdChFl     = rd && selChFl;
  wire logic [7:0] wd   = hwdata[7:0];
  wire mtc_ctrl_t wdCtrl = mtc_ctrl_t'(wd);
  wire mtc_chfl_t wdChFl = mtc_chfl_t'(wd);

  // Status clearing is refused during a protected break
  wire logic allowClr   = !breakState || breakClearEnable;

  // ----------------------------------------------------------------
  // Counter path
  // ----------------------------------------------------------------
  wire logic halted   = ctrl.halt || breakState || stopMode;
  wire logic clrNow   = wrCtrl && wdCtrl.clr;
  wire logic [15:0] period = {perHigh, perLow};
  wire logic atPeriod = (count == period);
  wire logic ovfEvent = tick && atPeriod && !clrNow;
  wire logic ovfSet   = ovfEvent && !perPending;

  mtc_prescaler u_prescaler (
    .clk       (clk),
    .rst_n     (rst_n),
    .clear     (clrNow),
    .run       (!halted),
    .divSel    (ctrl.divSel),
    .extClkPin (extClkPin),
    .tick      (tick)
  );

  // ----------------------------------------------------------------
  // Flag next values; a set in the clearing cycle wins
  // ----------------------------------------------------------------
  wire logic ovfClr = wrCtrl && !wdCtrl.ovf && ovfArmed && allowClr;
  wire logic next_ovf = ovfSet || (ctrl.ovf && !ovfClr);
  wire logic armOvf = rdCtrl && ctrl.ovf && allowClr;
  wire logic next_ovfArmed =
    !ovfSet && (armOvf || (ovfArmed && !(wrCtrl && allowClr)));

  wire logic [1:0] chWrAll = {2{wrChFl && allowClr}};
  wire logic [1:0] chClr   = chWrAll & ~wdChFl.flag & chArmed;
  wire logic [1:0] next_chFlag = chEvent | (chFl.flag & ~chClr);
  wire logic [1:0] chArm   = {2{rdChFl && allowClr}} & chFl.flag;
  wire logic [1:0] next_chArmed =
    ~chEvent & (chArm | (chArmed & ~chWrAll));

  // ----------------------------------------------------------------
  // Channel pins
  // ----------------------------------------------------------------
  // Buffered mode borrows channel 1, whose pin then drops out
  wire logic [1:0] next_chOe =
    chConfig.compare & ~{chConfig.buffered, 1'b0};
  wire logic [1:0] wrapTog = chConfig.toggle & {2{ovfEvent}} & next_chOe;
  wire logic [1:0] cmpHit  = chCompare & next_chOe & ~wrapTog;
  wire logic [1:0] next_chPin =
    ((chPinOut ^ wrapTog) & ~cmpHit) | (chCompareLevel & cmpHit);

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  wire logic [7:0] ctrlRd = {ctrl.ovf, ctrl.ovfIe, ctrl.halt,
                             1'b0, 1'b0, ctrl.divSel};
  wire logic [7:0] cntLRd = latched ? latchLow : count[7:0];
  wire logic [7:0] rdByte =
    selCtrl ? ctrlRd :
    selCntH ? count[15:8] :
    selCntL ? cntLRd :
    selPerH ? perHigh :
    selPerL ? perLow :
    selChFl ? chFl :
    selChCf ? chConfig : MTC_BYTE_0;
  // Irq level for wake-up is taken from the flags directly
  wire logic anyIrq = (ctrl.ovf && ctrl.ovfIe) ||
                      ((chFl.flag & chFl.irqEn) != MTC_CH_NONE);

  // ----------------------------------------------------------------
  // Bus phase; one wait state gives registered read data
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase     <= MTC_BUS_IDLE;
      reqAddr   <= MTC_BYTE_0;
      reqWrite  <= 1'b0;
      hreadyout <= 1'b1;
    end else if (busReq) begin
      phase     <= MTC_BUS_DATA;
      reqAddr   <= haddr[7:0];
      reqWrite  <= hwrite;
      hreadyout <= 1'b0;
    end else begin
      phase     <= MTC_BUS_IDLE;
      hreadyout <= 1'b1;
    end
  end

  // Read data; blocked or unmapped reads return zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= MTC_WORD_0;
      hresp  <= 1'b0;
    end else begin
      hrdata <= rd ? {MTC_PAD_0, rdByte} : MTC_WORD_0;
      hresp  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl     <= mtc_ctrl_t'(MTC_CTRL_RST);
      ovfArmed <= 1'b0;
    end else begin
      ctrl.ovf <= next_ovf;
      ovfArmed <= next_ovfArmed;
      if (wrCtrl) begin
        ctrl.ovfIe  <= wdCtrl.ovfIe;
        ctrl.halt   <= wdCtrl.halt;
        ctrl.divSel <= wdCtrl.divSel;
      end
    end
  end

  // Counter; clear beats a tick in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= MTC_CNT_ZERO;
    end else if (clrNow) begin
      count <= MTC_CNT_ZERO;
    end else if (tick) begin
      count <= atPeriod ? MTC_CNT_ZERO : count + MTC_CNT_ONE;
    end
  end

  // Period pair; the high byte arms the suppression
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      perHigh    <= MTC_PER_RST;
      perLow     <= MTC_PER_RST;
      perPending <= 1'b0;
    end else if (wrPerH) begin
      perHigh    <= wd;
      perPending <= 1'b1;
    end else if (wrPerL) begin
      perLow     <= wd;
      perPending <= 1'b0;
    end
  end

  // Coherent count read; clear also drops a stale latch
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latched  <= 1'b0;
      latchLow <= MTC_BYTE_0;
    end else if (clrNow) begin
      latched  <= 1'b0;
      latchLow <= MTC_BYTE_0;
    end else if (rdCntH && !latched) begin
      latched  <= 1'b1;
      latchLow <= count[7:0];
    end else if (rdCntL) begin
      latched  <= 1'b0;
    end
  end

  // Channel flags, enables and configuration
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chFl     <= mtc_chfl_t'(MTC_BYTE_0);
      chArmed  <= MTC_CH_NONE;
      chConfig <= mtc_chcf_t'(MTC_BYTE_0);
    end else begin
      chFl.flag <= next_chFlag;
      chArmed   <= next_chArmed;
      if (wrChFl) begin
        chFl.irqEn <= wdChFl.irqEn;
      end
      if (wrChCf) begin
        chConfig <= mtc_chcf_t'(wd);
      end
    end
  end

  // Pins and requests, all registered
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chPinOut    <= MTC_CH_NONE;
      chPinOe     <= MTC_CH_NONE;
      irqOverflow <= 1'b0;
      irqChannel  <= MTC_CH_NONE;
      wakeRequest <= 1'b0;
    end else begin
      chPinOut    <= next_chPin;
      chPinOe     <= next_chOe;
      irqOverflow <= ctrl.ovf && ctrl.ovfIe;
      irqChannel  <= chFl.flag & chFl.irqEn;
      wakeRequest <= waitMode && anyIrq;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_halt_clear_write;
    wrCtrl && wdCtrl.halt && wdCtrl.clr;
  endsequence

  sequence s_held_zero;
    (count == MTC_CNT_ZERO) [*2];
  endsequence

  a_ovf_on_match: assert property (
    ovfSet |=> ctrl.ovf)
    else $error("overflow flag missed a period match");

  a_wrap_to_zero: assert property (
    ovfEvent |=> count == MTC_CNT_ZERO)
    else $error("counter did not restart at zero");

  a_ovf_irq_gate: assert property (
    ##1 irqOverflow == $past(ctrl.ovf && ctrl.ovfIe))
    else $error("overflow request does not follow flag and enable");

  a_ch_flag_set: assert property (
    chEvent[0] |=> chFl.flag[0] ##1
      irqChannel[0] == $past(chFl.irqEn[0]))
    else $error("channel event not flagged or request wrong");

  a_ovf_clear_ok: assert property (
    ovfClr && !ovfSet |=> !ctrl.ovf)
    else $error("armed zero write did not clear overflow flag");

  a_ovf_no_clear: assert property (
    ctrl.ovf && !ovfArmed |=> ctrl.ovf)
    else $error("overflow flag cleared without read first");

  a_halt_freeze: assert property (
    ctrl.halt && !clrNow |=> $stable(count))
    else $error("counter moved while halted");

  a_clear_zero: assert property (
    clrNow |=> count == MTC_CNT_ZERO && !latched)
    else $error("clear bit did not zero the counter");

  a_halt_clear: assert property (
    s_halt_clear_write |=> s_held_zero)
    else $error("halt with clear did not hold zero");

  a_latch_hold: assert property (
    latched && !rdCntL && !clrNow |=> $stable(latchLow))
    else $error("latched low byte changed before low read");

  a_pend_block: assert property (
    perPending && !ctrl.ovf |=> !ctrl.ovf)
    else $error("overflow set while period write pending");

  a_stop_freeze: assert property (
    stopMode |=> $stable(count) && $stable(ctrl))
    else $error("state changed in stop mode");

  a_break_halt: assert property (
    breakState && !clrNow |=> $stable(count))
    else $error("counter moved during break");

  a_break_keep: assert property (
    breakState && !breakClearEnable && ctrl.ovf |=> ctrl.ovf)
    else $error("flag cleared during protected break");

  a_wait_block: assert property (
    waitMode && phase == MTC_BUS_DATA |=> hrdata == MTC_WORD_0)
    else $error("register read answered in wait mode");

  a_wrap_wins: assert property (
    wrapTog[0] |=> chPinOut[0] != $past(chPinOut[0]))
    else $error("wrap toggle lost to compare on pin");

endmodule : mtc_timer

// file: sim/mtc_cpu_model.sv
`timescale 1ns/1ps
module mtc_cpu_model
  import mtc_pkg::*;
(
  // Clock
  input  wire logic        clk,
  // AHB-Lite master side
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata
);
  // Bus starts idle with the slave selected
  initial begin
    hsel   = 1'b1;
    haddr  = MTC_WORD_0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = MTC_WORD_0;
  end

  // ----------------------------------------------------------------
  // Single word transfer, each phase held until hready is seen high
  // ----------------------------------------------------------------
  task automatic xfer(input logic wr, input logic [7:0] adr,
                      input logic [7:0] wd, output logic [7:0] rd);
    htrans <= 2'h2;
    haddr  <= {MTC_PAD_0, adr};
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {MTC_PAD_0, wd};
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata[7:0];
    // Stale write data is not left standing on the bus
    hwdata <= ~{MTC_PAD_0, wd};
  endtask : xfer
endmodule : mtc_cpu_model

// file: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import mtc_pkg::*;
;
  logic        clk;
  logic        rst_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        waitMode;
  logic        stopMode;
  logic        breakState;
  logic        breakClearEnable;
  logic        extClkPin;
  logic [1:0]  chEvent;
  logic [1:0]  chCompare;
  logic [1:0]  chCompareLevel;
  mtc_chcf_t   chConfig;
  logic [1:0]  chPinOut;
  logic [1:0]  chPinOe;
  logic        irqOverflow;
  logic [1:0]  irqChannel;
  logic        wakeRequest;
  logic [7:0]  rd;
  logic [15:0] cnt;
  int          failCount;
  int          checksDone;
  int          cycles = 0;

  mtc_cpu_model i_mtc_cpu_model (.clk(clk), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata));

  // Compare inputs come from the bench so the pin paths get exercised
  mtc_timer i_mtc_timer (.clk(clk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .waitMode(waitMode),
    .stopMode(stopMode), .breakState(breakState),
    .breakClearEnable(breakClearEnable), .extClkPin(extClkPin),
    .chEvent(chEvent), .chCompare(chCompare),
    .chCompareLevel(chCompareLevel), .chConfig(chConfig),
    .chPinOut(chPinOut), .chPinOe(chPinOe), .irqOverflow(irqOverflow),
    .irqChannel(irqChannel), .wakeRequest(wakeRequest));

  // ----------------------------------------------------------------
  // Clock, timeout and reporting
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // A hung handshake would otherwise stall the run forever
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failCount++;
      printVerdict();
    end
  end

  task automatic printVerdict();
    $display("checks %0d mismatches %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : printVerdict

  task automatic checkByte(input string nm, input logic [7:0] e, g);
    checksDone++;
    if (g !== e) begin
      failCount++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : checkByte

  task automatic checkBit(input string nm, input logic e, g);
    checksDone++;
    if (g !== e) begin
      failCount++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask : checkBit

  // Tolerance covers divider phase, unknown never matches
  task automatic checkCount(input string nm, input logic [15:0] e, g, tol);
    checksDone++;
    if ($isunknown(g) || g > e + tol || e > g + tol) begin
      failCount++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : checkCount

  task automatic wr(input logic [7:0] a, d);
    logic [7:0] x;
    i_mtc_cpu_model.xfer(1'b1, a, d, x);
  endtask : wr

  task automatic rdChk(input string nm, input logic [7:0] a, e);
    i_mtc_cpu_model.xfer(1'b0, a, MTC_BYTE_0, rd);
    checkByte(nm, e, rd);
  endtask : rdChk

  task automatic readCount(output logic [15:0] v);
    logic [7:0] h;
    logic [7:0] l;
    i_mtc_cpu_model.xfer(1'b0, MTC_OFS_CNTH, MTC_BYTE_0, h);
    i_mtc_cpu_model.xfer(1'b0, MTC_OFS_CNTL, MTC_BYTE_0, l);
    v = {h, l};
  endtask : readCount

  // Slow external clock edges, well under half the bus rate
  task automatic pulses(input int n);
    repeat (n) begin
      extClkPin <= 1'b1;
      repeat (4) @(posedge clk);
      extClkPin <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask : pulses

  task automatic endTest(input string nm);
    $display("test %s done", nm);
  endtask : endTest

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    failCount = 0;
    checksDone = 0;
    rst_n = 1'b0;
    chCompare = 2'h0;
    chCompareLevel = 2'h0;
    waitMode = 1'b0;
    stopMode = 1'b0;
    breakState = 1'b0;
    breakClearEnable = 1'b0;
    extClkPin = 1'b0;
    chEvent = 2'h0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdChk("ctrl", MTC_OFS_CTRL, MTC_CTRL_RST);
    rdChk("period high", MTC_OFS_PERH, MTC_PER_RST);
    rdChk("period low", MTC_OFS_PERL, MTC_PER_RST);
    readCount(cnt);
    checkCount("count", MTC_CNT_ZERO, cnt, 16'h0);
    wr(8'h1C, 8'hFF);
    rdChk("unmapped", 8'h1C, MTC_BYTE_0);
    checkBit("hresp", 1'b0, hresp);
    endTest("reset");
    // Each ratio runs 515 cycles between the run and halt writes
    for (int c = 0; c < 7; c++) begin
      wr(MTC_OFS_CTRL, 8'h30 | 8'(c));
      rdChk("ctrl", MTC_OFS_CTRL, 8'h20 | 8'(c));
      wr(MTC_OFS_CTRL, 8'(c));
      repeat (512) @(posedge clk);
      wr(MTC_OFS_CTRL, 8'h20 | 8'(c));
      readCount(cnt);
      checkCount("divided", 16'd515 >> c, cnt, 16'h1);
    end
    wr(MTC_OFS_CNTH, 8'h55);
    readCount(cnt);
    checkCount("halted", 16'd8, cnt, 16'h1);
    wr(MTC_OFS_CTRL, 8'h36);
    readCount(cnt);
    checkCount("cleared", MTC_CNT_ZERO, cnt, 16'h0);
    rdChk("period low", MTC_OFS_PERL, MTC_PER_RST);
    endTest("divider");
    wr(MTC_OFS_CTRL, 8'h37);
    wr(MTC_OFS_CTRL, 8'h07);
    pulses(5);
    rdChk("count high", MTC_OFS_CNTH, MTC_BYTE_0);
    pulses(2);
    rdChk("count high", MTC_OFS_CNTH, MTC_BYTE_0);
    rdChk("latched low", MTC_OFS_CNTL, 8'h05);
    readCount(cnt);
    checkCount("ext count", 16'd7, cnt, 16'h0);
    endTest("latch");
    wr(MTC_OFS_CTRL, 8'h37);
    wr(MTC_OFS_PERH, 8'h00);
    wr(MTC_OFS_PERL, 8'h02);
    wr(MTC_OFS_PERH, 8'h00);
    wr(MTC_OFS_CTRL, 8'h47);
    pulses(3);
    rdChk("ctrl", MTC_OFS_CTRL, 8'h47);
    checkBit("irq", 1'b0, irqOverflow);
    readCount(cnt);
    checkCount("wrapped", MTC_CNT_ZERO, cnt, 16'h0);
    wr(MTC_OFS_PERL, 8'h02);
    pulses(3);
    rdChk("ctrl", MTC_OFS_CTRL, 8'hC7);
    checkBit("irq", 1'b1, irqOverflow);
    readCount(cnt);
    checkCount("wrapped", MTC_CNT_ZERO, cnt, 16'h0);
    pulses(3);
    wr(MTC_OFS_CTRL, 8'h47);
    rdChk("ctrl", MTC_OFS_CTRL, 8'hC7);
    wr(MTC_OFS_CTRL, 8'h47);
    rdChk("ctrl", MTC_OFS_CTRL, 8'h47);
    wr(MTC_OFS_CTRL, 8'hC7);
    rdChk("ctrl", MTC_OFS_CTRL, 8'h47);
    repeat (2) @(posedge clk);
    checkBit("irq", 1'b0, irqOverflow);
    endTest("overflow");
    pulses(3);
    rdChk("ctrl", MTC_OFS_CTRL, 8'hC7);
    breakState <= 1'b1;
    pulses(2);
    readCount(cnt);
    checkCount("break", MTC_CNT_ZERO, cnt, 16'h0);
    rdChk("ctrl", MTC_OFS_CTRL, 8'hC7);
    wr(MTC_OFS_CTRL, 8'h47);
    rdChk("ctrl", MTC_OFS_CTRL, 8'hC7);
    breakState <= 1'b0;
    wr(MTC_OFS_CTRL, 8'h47);
    rdChk("ctrl", MTC_OFS_CTRL, 8'h47);
    pulses(3);
    breakClearEnable <= 1'b1;
    breakState <= 1'b1;
    rdChk("ctrl", MTC_OFS_CTRL, 8'hC7);
    wr(MTC_OFS_CTRL, 8'h47);
    breakState <= 1'b0;
    breakClearEnable <= 1'b0;
    rdChk("ctrl", MTC_OFS_CTRL, 8'h47);
    endTest("break");
    wr(MTC_OFS_CTRL, 8'h07);
    pulses(3);
    checkBit("irq", 1'b0, irqOverflow);
    wr(MTC_OFS_CTRL, 8'h47);
    repeat (2) @(posedge clk);
    checkBit("irq", 1'b1, irqOverflow);
    waitMode <= 1'b1;
    repeat (3) @(posedge clk);
    checkBit("wake", 1'b1, wakeRequest);
    rdChk("ctrl", MTC_OFS_CTRL, MTC_BYTE_0);
    wr(MTC_OFS_PERL, 8'h05);
    pulses(1);
    waitMode <= 1'b0;
    readCount(cnt);
    checkCount("wait count", 16'd1, cnt, 16'h0);
    stopMode <= 1'b1;
    pulses(2);
    stopMode <= 1'b0;
    readCount(cnt);
    checkCount("stop count", 16'd1, cnt, 16'h0);
    rdChk("period low", MTC_OFS_PERL, 8'h02);
    endTest("low power");
    wr(MTC_OFS_CHFL, 8'h10);
    chEvent <= 2'h1;
    @(posedge clk);
    chEvent <= 2'h2;
    @(posedge clk);
    chEvent <= 2'h0;
    repeat (3) @(posedge clk);
    checkBit("irq ch0", 1'b1, irqChannel[0]);
    checkBit("irq ch1", 1'b0, irqChannel[1]);
    rdChk("channel flags", MTC_OFS_CHFL, 8'h13);
    endTest("channels");
    wr(MTC_OFS_CHCF, 8'h37);
    rdChk("channel config", MTC_OFS_CHCF, 8'h37);
    checkByte("config port", 8'h37, chConfig);
    checkBit("oe ch0", 1'b1, chPinOe[0]);
    checkBit("oe ch1", 1'b0, chPinOe[1]);
    pulses(1);
    // Compare pulse lands in the cycle of the wrap tick
    extClkPin <= 1'b1;
    repeat (2) @(posedge clk);
    chCompare <= 2'h1;
    @(posedge clk);
    chCompare <= 2'h0;
    extClkPin <= 1'b0;
    repeat (2) @(posedge clk);
    checkBit("pin wrap", 1'b1, chPinOut[0]);
    chCompare <= 2'h1;
    @(posedge clk);
    chCompare <= 2'h0;
    @(posedge clk);
    checkBit("pin compare", 1'b0, chPinOut[0]);
    endTest("pins");
    printVerdict();
  end
endmodule : tb_top
